// [float_unpack_pkg.sv]
// Constants and types for the single-precision operand unpacker.
// Assumes operands arrive as bits 31..0, bit 0 in the lowest-addressed byte.
package float_unpack_pkg;

    localparam int OPERAND_W     = 32;
    localparam int BYTE_W        = 8;
    localparam int OPERAND_BYTES = 4;
    localparam int LANE_IDX_W    = 2;
    localparam int EXP_W         = 8;
    localparam int FRAC_W        = 24;

    // Field positions within the 32-bit operand
    localparam int SIGN_POS      = 15;
    localparam int EXP_MSB       = 14;
    localparam int EXP_LSB       = 7;
    localparam int FRAC_HI_MSB   = 6;
    localparam int FRAC_HI_LSB   = 0;
    localparam int FRAC_LO_MSB   = 31;
    localparam int FRAC_LO_LSB   = 16;

    // Excess-128 bias and the zero exponent field
    localparam logic [EXP_W-1:0] EXP_BIAS       = 8'h80;
    localparam logic [EXP_W-1:0] EXP_FIELD_ZERO = 8'h00;

    // Indices of the first byte and of the byte that completes an operand
    localparam logic [LANE_IDX_W-1:0] LAST_LANE  = 2'h3;
    localparam logic [LANE_IDX_W-1:0] FIRST_LANE = 2'h0;

    // Reset values of the result registers and the byte holding registers
    localparam logic [OPERAND_W-1:0] OPERAND_RST = 32'h0000_0000;
    localparam logic [FRAC_W-1:0]    FRAC_RST    = 24'h00_0000;
    localparam logic [EXP_W-1:0]     EXP_RST     = 8'h00;
    localparam logic [BYTE_W-1:0]    BYTE_RST    = 8'h00;

    typedef enum logic [1:0] {
        CLASS_NORMAL,
        CLASS_ZERO,
        CLASS_RESERVED
    } float_class_t;

    typedef enum logic {
        ASM_IDLE,
        ASM_COLLECT
    } asm_state_t;

endpackage

// [float_field_split.sv]
// Combinational splitter: sign, exponent, fraction and class of an operand.
// Assumes a whole 32-bit operand on its input; no state of its own.
`timescale 1ns/10ps
module float_field_split
    import float_unpack_pkg::*;
(
    input  wire logic [OPERAND_W-1:0] operand_i,
    output logic                      sign_o,
    output logic [EXP_W-1:0]          exp_field_o,
    output logic [EXP_W-1:0]          true_exp_o,
    output logic [FRAC_W-1:0]         fraction_o,
    output float_class_t              class_o
);

    wire                       sign_bit;
    wire [EXP_W-1:0]           exp_field;
    wire                       exp_is_zero;
    wire [FRAC_HI_MSB:0]       frac_hi;
    wire [FRAC_LO_MSB-FRAC_LO_LSB:0] frac_lo;
    wire [FRAC_W-1:0]          frac_full;
    wire [EXP_W-1:0]           exp_unbiased;

    assign sign_bit    = operand_i[SIGN_POS];
    assign exp_field   = operand_i[EXP_MSB:EXP_LSB];
    assign exp_is_zero = (exp_field == EXP_FIELD_ZERO);

    // hidden one, then 6..0, then 31..16
    assign frac_hi     = operand_i[FRAC_HI_MSB:FRAC_HI_LSB];
    assign frac_lo     = operand_i[FRAC_LO_MSB:FRAC_LO_LSB];
    assign frac_full   = {1'b1, frac_hi, frac_lo};

    // true exponent is field minus 128
    assign exp_unbiased = exp_field - EXP_BIAS;

    assign sign_o      = sign_bit;
    assign exp_field_o = exp_field;
    assign true_exp_o  = exp_is_zero ? EXP_RST : exp_unbiased;
    assign fraction_o  = exp_is_zero ? FRAC_RST : frac_full;

    // zero field with clear sign is exact zero
    // zero field with set sign is reserved
    assign class_o = !exp_is_zero ? CLASS_NORMAL
                   : (sign_bit ? CLASS_RESERVED : CLASS_ZERO);

endmodule

// [single_float_unpack_classify.sv]
// Single-precision operand unpacker: takes an operand either as a whole
// 32-bit value or as four bytes, lowest address first, and presents its
// sign, exponent, fraction and class registered one edge later.
// Assumes sources and consumer sit on clk_i; no synchronisers needed.
//
// What this block does
// - An operand is four consecutive bytes, bits 0 to 31 from the right, located by the byte holding bit 0.
// - The sign is bit 15 of the operand, one meaning negative.
// - The biased exponent is bits 14 down to 7, in excess-128.
// - The 24-bit fraction is a hidden one, then bits 6 to 0, then bits 31 to 16.
// - For field values 1 to 255 the true exponent is the field minus 128.
// - Zero field with sign clear is exact floating zero whatever the fraction.
// - Zero field with sign set is reserved and raises a reserved operand fault.
`timescale 1ns/10ps
module single_float_unpack_classify
    import float_unpack_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  reset_i,
    // Whole-operand path
    input  wire logic                  word_valid_i,
    input  wire logic [OPERAND_W-1:0]  word_i,
    // Byte path, lowest address first
    input  wire logic                  byte_valid_i,
    input  wire logic                  byte_first_i,
    input  wire logic [BYTE_W-1:0]     byte_i,
    // Unpacked result
    output logic                       valid_o,
    output logic                       sign_o,
    output logic [EXP_W-1:0]           exp_field_o,
    output logic [EXP_W-1:0]           true_exp_o,
    output logic [FRAC_W-1:0]          fraction_o,
    output logic                       zero_o,
    output logic                       reserved_o,
    output logic                       fault_o,
    output logic [OPERAND_W-1:0]       operand_o,
    output logic                       byte_drop_o
);

    import float_unpack_pkg::*;

    asm_state_t              state_r;
    asm_state_t              state_nxt;
    logic [LANE_IDX_W-1:0]   lane_r;
    logic [LANE_IDX_W-1:0]   lane_nxt;
    logic [BYTE_W-1:0]       lane_data_r [OPERAND_BYTES-1];

    logic                    valid_r;
    logic                    sign_r;
    logic [EXP_W-1:0]        exp_field_r;
    logic [EXP_W-1:0]        true_exp_r;
    logic [FRAC_W-1:0]       fraction_r;
    logic                    zero_r;
    logic                    reserved_r;
    logic                    fault_r;
    logic [OPERAND_W-1:0]    operand_r;
    logic                    byte_drop_r;

    wire                     byte_start;
    wire                     byte_cont;
    wire                     byte_take;
    wire                     byte_done;
    wire                     byte_stray;
    wire                     accept;
    wire [OPERAND_W-1:0]     asm_word;
    wire [OPERAND_W-1:0]     src_word;

    wire                     split_sign;
    wire [EXP_W-1:0]         split_exp_field;
    wire [EXP_W-1:0]         split_true_exp;
    wire [FRAC_W-1:0]        split_fraction;
    float_class_t            split_class;

    // Byte path decode; a whole operand aborts any partial byte assembly
    assign byte_start = byte_valid_i && byte_first_i && !word_valid_i;
    assign byte_cont  = byte_valid_i && !byte_first_i && !word_valid_i
                      && (state_r == ASM_COLLECT);
    assign byte_take  = byte_start || byte_cont;
    // fourth consecutive byte completes the operand
    assign byte_done  = byte_cont && (lane_r == LAST_LANE);
    assign byte_stray = byte_valid_i && !byte_first_i && !word_valid_i
                      && (state_r == ASM_IDLE);

    // bit 0 sits in the first (lowest-addressed) byte
    assign asm_word = {byte_i, lane_data_r[2], lane_data_r[1],
                       lane_data_r[0]};
    assign src_word = word_valid_i ? word_i : asm_word;
    assign accept   = word_valid_i || byte_done;

    // Assembler next state
    always_comb begin
        state_nxt = state_r;
        lane_nxt  = lane_r;
        if (word_valid_i) begin
            state_nxt = ASM_IDLE;
            lane_nxt  = FIRST_LANE;
        end else if (byte_start) begin
            state_nxt = ASM_COLLECT;
            lane_nxt  = LANE_IDX_W'(FIRST_LANE + 2'h1);
        end else if (byte_done) begin
            state_nxt = ASM_IDLE;
            lane_nxt  = FIRST_LANE;
        end else if (byte_cont) begin
            case (state_r)
                ASM_COLLECT: lane_nxt = LANE_IDX_W'(lane_r + 2'h1);
                default:     lane_nxt = FIRST_LANE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_r <= ASM_IDLE;
            lane_r  <= FIRST_LANE;
        end else begin
            state_r <= state_nxt;
            lane_r  <= lane_nxt;
        end
    end

    // One holding register per low byte lane
    genvar gi;
    generate
        for (gi = 0; gi < OPERAND_BYTES - 1; gi++) begin : g_lane
            wire lane_load;
            // byte stored by its position in the operand
            assign lane_load = byte_take
                && (byte_start ? (gi == 0)
                               : (lane_r == LANE_IDX_W'(gi)));
            always_ff @(posedge clk_i) begin
                if (reset_i) begin
                    lane_data_r[gi] <= BYTE_RST;
                end else if (lane_load) begin
                    lane_data_r[gi] <= byte_i;
                end
            end
        end
    endgenerate

    float_field_split u_split (
        .operand_i   (src_word),
        .sign_o      (split_sign),
        .exp_field_o (split_exp_field),
        .true_exp_o  (split_true_exp),
        .fraction_o  (split_fraction),
        .class_o     (split_class)
    );

    // result registers, one edge after acceptance
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            valid_r     <= 1'b0;
            sign_r      <= 1'b0;
            exp_field_r <= EXP_RST;
            true_exp_r  <= EXP_RST;
            fraction_r  <= FRAC_RST;
            zero_r      <= 1'b0;
            reserved_r  <= 1'b0;
            operand_r   <= OPERAND_RST;
        end else begin
            valid_r <= accept;
            if (accept) begin
                sign_r      <= split_sign;
                exp_field_r <= split_exp_field;
                true_exp_r  <= split_true_exp;
                fraction_r  <= split_fraction;
                zero_r      <= (split_class == CLASS_ZERO);
                reserved_r  <= (split_class == CLASS_RESERVED);
                operand_r   <= src_word;
            end
        end
    end

    // Fault and stray-byte pulses
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            fault_r     <= 1'b0;
            byte_drop_r <= 1'b0;
        end else begin
            fault_r     <= accept && (split_class == CLASS_RESERVED);
            byte_drop_r <= byte_stray
                        || (byte_valid_i && word_valid_i);
        end
    end

    assign valid_o     = valid_r;
    assign sign_o      = sign_r;
    assign exp_field_o = exp_field_r;
    assign true_exp_o  = true_exp_r;
    assign fraction_o  = fraction_r;
    assign zero_o      = zero_r;
    assign reserved_o  = reserved_r;
    assign fault_o     = fault_r;
    assign operand_o   = operand_r;
    assign byte_drop_o = byte_drop_r;

endmodule

// [float_unpack_props.sv]
// Checker for the operand unpacker, bound to its top module.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
module float_unpack_props
    import float_unpack_pkg::*;
(
    input wire logic                 clk_i,
    input wire logic                 reset_i,
    input wire logic                 word_valid_i,
    input wire logic [OPERAND_W-1:0] word_i,
    input wire logic                 valid_o,
    input wire logic                 sign_o,
    input wire logic [EXP_W-1:0]     exp_field_o,
    input wire logic [EXP_W-1:0]     true_exp_o,
    input wire logic [FRAC_W-1:0]    fraction_o,
    input wire logic                 zero_o,
    input wire logic                 reserved_o,
    input wire logic                 fault_o,
    input wire logic [OPERAND_W-1:0] operand_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_word_capture: assert property (word_valid_i |=>
        operand_o == $past(word_i)) else $error("operand not captured");
    a_sign_bit: assert property (word_valid_i |=>
        sign_o == $past(word_i[15])) else $error("sign wrong");
    a_exp_field: assert property (word_valid_i |=>
        exp_field_o == $past(word_i[14:7])) else $error("exponent wrong");
    a_frac_order: assert property (word_valid_i && word_i[14:7] != 0
        |=> fraction_o == {1'b1, $past(word_i[6:0]), $past(word_i[31:16])})
        else $error("fraction wrong");
    a_true_exp: assert property (valid_o && exp_field_o != 0 |->
        true_exp_o == exp_field_o - 8'h80) else $error("true exp wrong");
    a_zero_flag: assert property (valid_o |->
        zero_o == (exp_field_o == 0 && !sign_o)) else $error("zero flag");
    a_reserved_fault: assert property (valid_o |->
        reserved_o == (exp_field_o == 0 && sign_o) && fault_o == reserved_o)
        else $error("reserved flag");
    a_valid_latency: assert property (word_valid_i |=> valid_o)
        else $error("valid late");
    a_reset_clear: assert property (disable iff (1'b0) reset_i |=>
        !valid_o && !fault_o && operand_o == 0) else $error("not cleared");
endmodule

bind single_float_unpack_classify float_unpack_props float_unpack_props_i (
    .clk_i(clk_i), .reset_i(reset_i), .word_valid_i(word_valid_i),
    .word_i(word_i), .valid_o(valid_o), .sign_o(sign_o),
    .exp_field_o(exp_field_o), .true_exp_o(true_exp_o),
    .fraction_o(fraction_o), .zero_o(zero_o), .reserved_o(reserved_o),
    .fault_o(fault_o), .operand_o(operand_o));

// [float_consumer_model.sv]
// Execution-side consumer: counts results taken and faults raised.
// Assumes results arrive as one-cycle pulses on clk_i.
`timescale 1ns/10ps
module float_consumer_model (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic valid_i,
    input  wire logic fault_i,
    output int        taken_o,
    output int        faults_o
);
    always @(posedge clk_i) begin
        if (reset_i) begin
            taken_o <= 0;
            faults_o <= 0;
        end else if (valid_i) begin
            taken_o <= taken_o + 1;
            if (fault_i === 1'b1) faults_o <= faults_o + 1;
        end
    end
endmodule

// [testbench.sv]
// Self-checking bench for the operand unpacker.
// Assumes a 50 MHz clock and the consumer model beside the block.
`timescale 1ns/10ps
module testbench;
    import float_unpack_pkg::*;
    logic clk_i, reset_i, word_valid_i, byte_valid_i, byte_first_i;
    logic [31:0] word_i;
    logic [7:0]  byte_i;
    logic valid_o, sign_o, zero_o, reserved_o, fault_o, byte_drop_o;
    logic [7:0]  exp_field_o, true_exp_o;
    logic [23:0] fraction_o;
    logic [31:0] operand_o;
    int num_errors, compares, cycles, taken, faults;
    logic [31:0] words [7] = '{32'h0000_4080, 32'h1234_C0FF,
        32'hFFFF_7FFF, 32'h0001_0080, 32'hABCD_007F, 32'h0000_8000,
        32'h5555_8005};

    single_float_unpack_classify single_float_unpack_classify_i (.*);
    float_consumer_model float_consumer_model_i (.clk_i(clk_i),
        .reset_i(reset_i), .valid_i(valid_o), .fault_i(fault_o),
        .taken_o(taken), .faults_o(faults));

    initial begin
        clk_i = 0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic report_and_stop();
        if (num_errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_out(input logic [31:0] w);
        logic [7:0] f;
        f = w[14:7];
        cmp(valid_o, 1);
        cmp(operand_o, w);
        cmp(sign_o, w[15]);
        cmp(exp_field_o, f);
        cmp(fraction_o, f != 0 ? {1'b1, w[6:0], w[31:16]} : 0);
        cmp(true_exp_o, f != 0 ? 8'(f - 8'h80) : 8'h00);
        cmp(zero_o, f == 0 && !w[15]);
        cmp(reserved_o, f == 0 && w[15]);
        cmp(fault_o, f == 0 && w[15]);
    endtask

    task automatic do_reset();
        @(posedge clk_i) reset_i <= 1;
        repeat (12) @(posedge clk_i);
        #1;
        cmp(valid_o, 0);
        cmp(operand_o, 0);
        cmp(fraction_o, 0);
        @(posedge clk_i) reset_i <= 0;
    endtask

    task automatic word_stream();
        for (int k = 0; k <= 7; k++) begin
            @(posedge clk_i);
            word_valid_i <= k < 7;
            if (k < 7) word_i <= words[k];
            #1;
            if (k > 0) check_out(words[k-1]);
        end
        @(posedge clk_i) #1;
        cmp(valid_o, 0);
    endtask

    task automatic put_byte(input logic [7:0] b, input logic first);
        @(posedge clk_i);
        byte_valid_i <= 1;
        byte_first_i <= first;
        byte_i <= b;
    endtask

    task automatic byte_path();
        put_byte(8'h11, 0);
        @(posedge clk_i) byte_valid_i <= 0;
        #1 cmp(byte_drop_o, 1);
        put_byte(8'h80, 1);
        put_byte(8'hC0, 0);
        @(posedge clk_i) byte_valid_i <= 0;
        put_byte(8'h34, 0);
        put_byte(8'h12, 0);
        @(posedge clk_i) byte_valid_i <= 0;
        #1 check_out(32'h1234_C080);
        // Whole operand beats a partial byte assembly and discards it
        put_byte(8'h80, 1);
        put_byte(8'hC0, 0);
        word_valid_i <= 1;
        word_i <= words[2];
        put_byte(8'h34, 0);
        word_valid_i <= 0;
        #1 check_out(words[2]);
        cmp(byte_drop_o, 1);
        @(posedge clk_i) byte_valid_i <= 0;
        #1 cmp(byte_drop_o, 1);
        cmp(valid_o, 0);
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            report_and_stop();
        end
    end

    initial begin
        reset_i = 1;
        word_valid_i = 0;
        byte_valid_i = 0;
        byte_first_i = 0;
        word_i = 0;
        byte_i = 0;
        repeat (12) @(posedge clk_i);
        reset_i <= 0;
        word_stream();
        do_reset();
        word_stream();
        byte_path();
        @(posedge clk_i) #1;
        cmp(taken, 9);
        cmp(faults, 2);
        report_and_stop();
    end
endmodule
